// ===== verilog/reset_strap_defines.svh
// Constants for the reset and strap configuration block
`ifndef RESET_STRAP_DEFINES_SVH
`define RESET_STRAP_DEFINES_SVH

`define TEST_NORMAL 2'b00
`define TEST_NAND 2'b11
`define NAND_WIDTH 8
`define STRAP_WIDTH 9

`endif

// ===== verilog/reset_strap_pkg.sv
// Types for the reset and strap configuration block
package reset_strap_pkg;
    typedef enum logic [1:0] {
        MASTER_STYLE_A,
        MASTER_STYLE_B,
        MASTER_STYLE_C
    } master_style_t;
    typedef enum logic {
        SLAVE_A_PLUS_C,
        SLAVE_A_PLUS_B
    } slave_style_t;
    typedef enum logic [1:0] {
        MODE_NORMAL,
        MODE_RESERVED,
        MODE_NAND_TREE
    } test_mode_t;
endpackage

// ===== verilog/reset_sync.sv
// Reset synchroniser: asynchronous assert, clocked release
`timescale 1ns/1ps
module reset_sync (
    // Clock and raw reset
    input wire logic clock,
    input wire logic rawRst_n,
    // Synchronised reset
    output logic syncRst_n
);
    logic stage1_r;
    logic stage2_r;

    // Release only on a clock edge so no flop sees a runt release
    always_ff @(posedge clock or negedge rawRst_n) begin
        if (!rawRst_n) begin
            stage1_r <= 1'b0;
            stage2_r <= 1'b0;
        end else begin
            stage1_r <= 1'b1;
            stage2_r <= stage1_r;
        end
    end

    assign syncRst_n = stage2_r;
endmodule

// ===== verilog/sync_bit.sv
// Two-flop level synchroniser
`timescale 1ns/1ps
module sync_bit (
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // Level in and out
    input wire logic d,
    input wire logic resetVal,
    output logic q
);
    logic meta_r;
    logic q_r;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            meta_r <= 1'b0;
            q_r <= 1'b0;
        end else begin
            meta_r <= d;
            q_r <= meta_r;
        end
    end

    assign q = q_r ^ resetVal;
endmodule

// ===== verilog/bridge_reset_and_strap_config.sv
// Reset control and reset-time strap sampling for the bus bridge
`timescale 1ns/1ps
`include "reset_strap_defines.svh"
module bridge_reset_and_strap_config (
    // PCI clock domain
    input wire logic clock,
    input wire logic arst_n,
    // Reset pins
    input wire logic localResetIn_n,
    input wire logic backendHealthy_n,
    output logic localResetOut_n,
    // Software control from register file
    input wire logic softResetHoldWrite,
    input wire logic softResetHoldData,
    input wire logic accessBlockWrite,
    input wire logic accessBlockData,
    output logic softResetHold,
    output logic pciAccessBlock,
    // Straps
    input wire logic masterEnableStrap,
    input wire logic burstProgressStrap,
    input wire logic transferWidthStrap,
    input wire logic eepromEnableStrap,
    input wire logic serialDataIn,
    input wire logic arbiterEnableStrap,
    input wire logic [1:0] testSelect,
    // Configuration results
    output logic pciMasterEnableBit,
    output reset_strap_pkg::master_style_t masterStyle,
    output reset_strap_pkg::slave_style_t slaveStyle,
    output logic eepromLoadStart,
    output logic arbiterEnable,
    output reset_strap_pkg::test_mode_t testMode,
    // NAND tree test
    input wire logic [`NAND_WIDTH-1:0] nandTreeIn,
    output logic serialClockOut,
    output logic serialClockOe,
    output logic outputsTristate,
    // PCI target control
    input wire logic targetSelected,
    output logic targetDecodeEnable,
    output logic devselForceOff,
    // Internal resets
    output logic deviceInReset,
    output logic coreRst_n
);
    import reset_strap_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    logic pciRst_n;
    logic localInRst_n;
    logic healthyRaw;
    logic localIn_s;
    logic unhealthy_s;
    logic anyRst_n;
    logic strapTaken_r;
    logic sampleStraps;
    logic [`STRAP_WIDTH-1:0] strap_s;

    // each reset released cleanly on a clock edge
    reset_sync pciRstSync (
        .clock(clock),
        .rawRst_n(arst_n),
        .syncRst_n(pciRst_n)
    );
    reset_sync localRstSync (
        .clock(clock),
        .rawRst_n(localResetIn_n),
        .syncRst_n(localInRst_n)
    );
    sync_bit healthySync (
        .clock(clock),
        .arst_n(arst_n),
        .d(backendHealthy_n),
        .resetVal(1'b0),
        .q(healthyRaw)
    );
    sync_bit localInSync (
        .clock(clock),
        .arst_n(arst_n),
        .d(localResetIn_n),
        .resetVal(1'b0),
        .q(localIn_s)
    );
    assign unhealthy_s = healthyRaw;

    // Straps are pins: two flops before sampling
    genvar g;
    generate
        for (g = 0; g < `STRAP_WIDTH; g = g + 1) begin : gStrap
            logic pin;
            if (g == 0) begin : gA
                assign pin = masterEnableStrap;
            end else if (g == 1) begin : gB
                assign pin = burstProgressStrap;
            end else if (g == 2) begin : gC
                assign pin = transferWidthStrap;
            end else if (g == 3) begin : gD
                assign pin = eepromEnableStrap;
            end else if (g == 4) begin : gE
                assign pin = serialDataIn;
            end else if (g == 5) begin : gF
                assign pin = accessBlockData;
            end else if (g == 6) begin : gG
                assign pin = arbiterEnableStrap;
            end else begin : gH
                assign pin = testSelect[g-7];
            end
            sync_bit strapSync (
                .clock(clock),
                .arst_n(arst_n),
                .d(pin),
                .resetVal(1'b0),
                .q(strap_s[g])
            );
        end
    endgenerate

    assign anyRst_n = pciRst_n & localIn_s & ~unhealthy_s;

    // One sample past release: PCI reset also clears the strap flops
    assign sampleStraps = ~anyRst_n | ~strapTaken_r;

    ////////////////////////////////////////////////////////////////////////
    // Decode of the style straps, used for master and slave
    function automatic master_style_t decodeMaster(input logic bp,
                                                   input logic wd);
        if (!bp) begin
            decodeMaster = MASTER_STYLE_A;
        end else if (wd) begin
            decodeMaster = MASTER_STYLE_B;
        end else begin
            decodeMaster = MASTER_STYLE_C;
        end
    endfunction

    function automatic slave_style_t decodeSlave(input logic wd);
        if (wd) begin
            decodeSlave = SLAVE_A_PLUS_B;
        end else begin
            decodeSlave = SLAVE_A_PLUS_C;
        end
    endfunction

    function automatic test_mode_t decodeTest(input logic [1:0] ts);
        if (ts == `TEST_NORMAL) begin
            decodeTest = MODE_NORMAL;
        end else if (ts == `TEST_NAND) begin
            decodeTest = MODE_NAND_TREE;
        end else begin
            decodeTest = MODE_RESERVED;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Soft reset hold: PCI reset or local reset input clears it, never reset by itself
    // this bit feeds no internal reset
    always_ff @(posedge clock or negedge pciRst_n) begin
        if (!pciRst_n) begin
            softResetHold <= 1'b0;
        end else if (!localIn_s) begin
            softResetHold <= 1'b0;
        end else if (softResetHoldWrite) begin
            softResetHold <= softResetHoldData;
        end
    end

    // Local reset output, PCI side view
    always_ff @(posedge clock or negedge pciRst_n) begin
        if (!pciRst_n) begin
            localResetOut_n <= 1'b0;
        end else if (!localIn_s) begin
            localResetOut_n <= 1'b1;
        end else if (softResetHoldWrite) begin
            localResetOut_n <= ~softResetHoldData;
        end else begin
            localResetOut_n <= ~softResetHold;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Straps sampled while any reset is held, frozen after release
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            strapTaken_r <= 1'b0;
        end else begin
            strapTaken_r <= anyRst_n;
        end
    end

    // Bus master enable
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pciMasterEnableBit <= 1'b0;
        end else if (sampleStraps) begin
            pciMasterEnableBit <= strap_s[0];
        end
    end

    // Local bus master style
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            masterStyle <= MASTER_STYLE_A;
        end else if (sampleStraps) begin
            masterStyle <= decodeMaster(strap_s[1], strap_s[2]);
        end
    end

    // Local bus slave style
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            slaveStyle <= SLAVE_A_PLUS_C;
        end else if (sampleStraps) begin
            slaveStyle <= decodeSlave(strap_s[2]);
        end
    end

    // Arbiter enable
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            arbiterEnable <= 1'b0;
        end else if (sampleStraps) begin
            arbiterEnable <= strap_s[6];
        end
    end

    // Test mode; held until the next reset
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            testMode <= MODE_NORMAL;
        end else if (sampleStraps) begin
            testMode <= decodeTest(strap_s[8:7]);
        end
    end

    // One pulse at release requests the EEPROM download
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            eepromLoadStart <= 1'b0;
        end else begin
            eepromLoadStart <= anyRst_n & ~strapTaken_r
                               & (strap_s[3] | strap_s[4]);
        end
    end

    // Access block: strap at reset, cleared by local processor
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pciAccessBlock <= 1'b0;
        end else if (sampleStraps) begin
            pciAccessBlock <= strap_s[5];
        end else if (accessBlockWrite && !accessBlockData) begin
            pciAccessBlock <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Target gating; PCI side runs on PCI clock alone
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            targetDecodeEnable <= 1'b0;
        end else begin
            targetDecodeEnable <= localIn_s;
        end
    end

    // Only a cycle already claimed needs its DEVSEL dropped
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            devselForceOff <= 1'b0;
        end else begin
            devselForceOff <= ~localIn_s & targetSelected;
        end
    end

    // NAND tree onto serial clock pin; all else tristated
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            serialClockOut <= 1'b1;
        end else begin
            serialClockOut <= ~(&nandTreeIn);
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            serialClockOe <= 1'b0;
        end else begin
            serialClockOe <= (testMode == MODE_NAND_TREE);
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            outputsTristate <= 1'b0;
        end else begin
            outputsTristate <= (testMode == MODE_NAND_TREE);
        end
    end

    // Reset view of the whole device
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            deviceInReset <= 1'b1;
        end else begin
            deviceInReset <= ~anyRst_n;
        end
    end

    // Core reset: local input and PCI reset each assert all of it alike
    // The hold bit never reaches here, so soft reset stays external
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            coreRst_n <= 1'b0;
        end else begin
            coreRst_n <= pciRst_n & localInRst_n;
        end
    end
endmodule

// ===== tb/local_host_model.sv
// Local bus host model driving the local reset input pin
`timescale 1ns/1ps
module local_host_model (
    // Request from bench
    input wire logic holdReset,
    // Reset pins
    input wire logic localResetOut_n,
    output logic localResetIn_n,
    output int outRises
);
    initial localResetIn_n = 1'b1;
    initial outRises = 0;
    // Pin moves off the clock edge on purpose
    always @(holdReset) localResetIn_n <= #3 ~holdReset;
    always @(posedge localResetOut_n) outRises++;
endmodule

// ===== tb/bridge_reset_properties.sv
// Port checker for the reset and strap block
`timescale 1ns/1ps
`include "reset_strap_defines.svh"
module bridge_reset_properties (
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // Inputs
    input wire logic localResetIn_n,
    input wire logic backendHealthy_n,
    input wire logic softResetHoldWrite,
    input wire logic softResetHoldData,
    input wire logic targetSelected,
    input wire logic [`NAND_WIDTH-1:0] nandTreeIn,
    // Outputs
    input wire logic localResetOut_n,
    input wire logic softResetHold,
    input wire logic pciMasterEnableBit,
    input wire reset_strap_pkg::master_style_t masterStyle,
    input wire reset_strap_pkg::test_mode_t testMode,
    input wire logic serialClockOut,
    input wire logic outputsTristate,
    input wire logic targetDecodeEnable,
    input wire logic devselForceOff,
    input wire logic eepromLoadStart,
    input wire logic deviceInReset,
    input wire logic coreRst_n
);
    import reset_strap_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);
    ////////////////////////
    a_write_sets: assert property (
        (localResetIn_n && !backendHealthy_n)[*4] ##0 (softResetHoldWrite
        && softResetHoldData && coreRst_n)
        |=> softResetHold && !localResetOut_n && coreRst_n)
        else $error("hold set");
    a_write_clears: assert property (
        (localResetIn_n && !backendHealthy_n)[*4] ##0 (softResetHoldWrite
        && !softResetHoldData) |=> !softResetHold && localResetOut_n)
        else $error("hold clear");
    a_local_clears: assert property (
        (!localResetIn_n)[*4]
        |-> !softResetHold && localResetOut_n && !targetDecodeEnable)
        else $error("local reset");
    a_devsel_drop: assert property (
        ((!localResetIn_n)[*4] ##0 targetSelected) |=> devselForceOff)
        else $error("devsel kept");
    a_pci_release: assert property (
        $rose(arst_n) |-> !softResetHold && deviceInReset
        && (backendHealthy_n || !localResetOut_n))
        else $error("pci reset");
    a_unhealthy_rst: assert property (
        backendHealthy_n[*4] |-> deviceInReset) else $error("unhealthy");
    a_cfg_frozen: assert property (
        (!deviceInReset)[*4] |-> $stable(pciMasterEnableBit)
        && $stable(masterStyle) && $stable(testMode))
        else $error("config moved");
    a_nand_out: assert property (
        (testMode == MODE_NAND_TREE)[*2]
        |-> serialClockOut == ~(&$past(nandTreeIn)) && outputsTristate)
        else $error("nand tree");
    a_normal_out: assert property (
        (testMode == MODE_NORMAL)[*2] |-> !outputsTristate)
        else $error("tristate");
    a_ee_pulse: assert property (
        eepromLoadStart |=> !eepromLoadStart) else $error("ee pulse");
endmodule
bind bridge_reset_and_strap_config bridge_reset_properties u_props (.*);

// ===== tb/tb.sv
// Self-checking bench for the reset and strap block
`timescale 1ns/1ps
`include "reset_strap_defines.svh"
`define CHK(g, e) begin samplesChecked++; if ((g) !== (e)) begin \
    fails++; $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
    import reset_strap_pkg::*;
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic hostRst = 1'b0;
    logic backendHealthy_n = 1'b0;
    logic wrHold = 1'b0, wrData = 1'b0, wrBlock = 1'b0, blkData = 1'b0;
    logic targetSelected = 1'b0;
    logic [7:0] straps = 8'h00;
    logic [16:0] seed = 17'h170de;
    logic [`NAND_WIDTH-1:0] nandTreeIn = '0;
    logic localResetIn_n, localResetOut_n, softResetHold, pciAccessBlock;
    logic pciMasterEnableBit, eepromLoadStart, arbiterEnable;
    master_style_t masterStyle;
    slave_style_t slaveStyle;
    test_mode_t testMode;
    logic serialClockOut, serialClockOe, outputsTristate;
    logic targetDecodeEnable, devselForceOff, deviceInReset, coreRst_n;
    int fails = 0, samplesChecked = 0, eeCount = 0, outRises;
    ////////////////////////
    bridge_reset_and_strap_config u_dut (.softResetHoldWrite(wrHold),
        .softResetHoldData(wrData), .accessBlockWrite(wrBlock),
        .accessBlockData(blkData), .masterEnableStrap(straps[0]),
        .burstProgressStrap(straps[1]), .transferWidthStrap(straps[2]),
        .eepromEnableStrap(straps[3]), .serialDataIn(straps[4]),
        .arbiterEnableStrap(straps[5]), .testSelect(straps[7:6]), .*);
    local_host_model u_host (.holdReset(hostRst), .*);
    always #5 clock = ~clock;
    function automatic logic [16:0] lfsr(input logic [16:0] s);
        return {s[15:0], s[16] ^ s[13]};
    endfunction
    always @(posedge clock) begin
        seed <= lfsr(seed);
        nandTreeIn <= seed[7:0];
        if (eepromLoadStart === 1'b1) eeCount++;
    end
    ////////////////////////
    task automatic wrap_up();
        $display("Checked %0d, mismatches %0d", samplesChecked, fails);
        if (fails == 0 && samplesChecked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic softWrite(input logic d);
        @(posedge clock);
        wrHold <= 1'b1;
        wrData <= d;
        @(posedge clock);
        wrHold <= 1'b0;
        #1;
    endtask
    task automatic waitReset(input logic v);
        int k;
        for (k = 0; k < 20 && deviceInReset !== v; k++) tick(1);
        if (k == 20) begin
            fails++;
            wrap_up();
        end
    endtask
    task automatic checkCfg(input logic [7:0] s);
        master_style_t m;
        test_mode_t t;
        m = !s[1] ? MASTER_STYLE_A : (s[2] ? MASTER_STYLE_B : MASTER_STYLE_C);
        t = s[7:6] == 2'h0 ? MODE_NORMAL : MODE_RESERVED;
        if (s[7:6] == 2'h3) t = MODE_NAND_TREE;
        `CHK(pciMasterEnableBit, s[0])
        `CHK(masterStyle, m)
        `CHK(slaveStyle, s[2] ? SLAVE_A_PLUS_B : SLAVE_A_PLUS_C)
        `CHK(arbiterEnable, s[5])
        `CHK(testMode, t)
        `CHK(outputsTristate, s[7:6] == 2'h3)
        `CHK(serialClockOe, s[7:6] == 2'h3)
    endtask
    ////////////////////////
    initial begin
        logic [7:0] s;
        int e;
        repeat (3) @(posedge clock);
        arst_n <= 1'b1;
        waitReset(1'b0);
        for (int i = 0; i < 4; i++) begin
            @(posedge clock);
            s = {i[1:0], seed[5:3], i[1:0], seed[0]};
            straps <= s;
            arst_n <= 1'b0;
            e = eeCount;
            tick(5);
            @(posedge clock);
            arst_n <= 1'b1;
            waitReset(1'b0);
            tick(4);
            checkCfg(s);
            `CHK(eeCount - e, int'(s[3] | s[4]))
            @(posedge clock);
            straps <= ~s;
            tick(6);
            checkCfg(s);
        end
        softWrite(1'b1);
        `CHK({softResetHold, localResetOut_n}, 2'h2)
        `CHK({coreRst_n, deviceInReset}, 2'h2)
        e = outRises;
        softWrite(1'b0);
        `CHK({softResetHold, localResetOut_n}, 2'h1)
        `CHK(outRises - e, 1)
        softWrite(1'b1);
        @(posedge clock);
        s = {2'h0, seed[5:0]};
        straps <= s;
        hostRst <= 1'b1;
        targetSelected <= 1'b1;
        tick(6);
        `CHK({softResetHold, localResetOut_n}, 2'h1)
        `CHK({targetDecodeEnable, devselForceOff}, 2'h1)
        `CHK(deviceInReset, 1'b1)
        `CHK(coreRst_n, 1'b0)
        softWrite(1'b1);
        `CHK(softResetHold, 1'b0)
        @(posedge clock);
        hostRst <= 1'b0;
        targetSelected <= 1'b0;
        waitReset(1'b0);
        tick(4);
        checkCfg(s);
        `CHK(targetDecodeEnable, 1'b1)
        softWrite(1'b1);
        @(posedge clock);
        arst_n <= 1'b0;
        blkData <= 1'b1;
        tick(3);
        `CHK({softResetHold, localResetOut_n}, 2'h0)
        @(posedge clock);
        arst_n <= 1'b1;
        waitReset(1'b0);
        tick(3);
        `CHK({softResetHold, localResetOut_n}, 2'h1)
        `CHK(pciAccessBlock, 1'b1)
        @(posedge clock);
        wrBlock <= 1'b1;
        blkData <= 1'b0;
        @(posedge clock);
        wrBlock <= 1'b0;
        tick(1);
        `CHK(pciAccessBlock, 1'b0)
        @(posedge clock);
        backendHealthy_n <= 1'b1;
        waitReset(1'b1);
        `CHK(deviceInReset, 1'b1)
        @(posedge clock);
        backendHealthy_n <= 1'b0;
        waitReset(1'b0);
        wrap_up();
    end
endmodule
